//--- hdl/uid_rom_regs.sv
// Module: unique identifier registers and configuration ROM address mapping
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
module uid_rom_regs
(
	input wire logic CLK, // 100 MHz clock
	input wire logic SYS_RST, // Global power-on reset, sync high
	input wire logic CE, // Clock enable, freezes state when low
	input wire logic HOST_BUS_RESET, // Host bus reset level, pin
	input wire logic EEPROM_PRESENT, // EEPROM detected level, pin
	input wire logic EE_LOAD_VALID, // EEPROM loader word pair valid
	input wire logic [31:0] EE_UID_UPPER, // EEPROM upper identifier
	input wire logic [31:0] EE_UID_LOWER, // EEPROM lower identifier
	input wire logic [uid_rom_pkg::ADDR_W-1:0] ADDR, // Register byte address
	input wire logic [31:0] WDATA, // Write data
	input wire logic WR, // Write strobe
	input wire logic RD, // Read strobe
	output logic [31:0] RDATA, // Read data, cycle after RD
	input wire logic ROM_REQ, // Incoming quadlet read request
	input wire logic [47:0] ROM_OFS, // 1394 offset of request
	output logic ROM_HIT, // Mapped request pulse
	output logic [31:0] ROM_HOST_ADDR, // Host memory address
	output logic UID_LOCKED // Identifier locked status
);
	import uid_rom_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [1:0] bus_rst_sync_r, bus_rst_sync_nxt;
	logic [1:0] eep_sync_r, eep_sync_nxt;
	logic bus_rst;
	logic ee_present;

	// Two flops, only the second is read by logic
	always_comb
	begin
		bus_rst_sync_nxt = {bus_rst_sync_r[0], HOST_BUS_RESET};
		eep_sync_nxt = {eep_sync_r[0], EEPROM_PRESENT};
	end

	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			// Reset as held, so no false window before the pin drops
			bus_rst_sync_r <= 2'b11;
			eep_sync_r <= 2'b00;
		end
		else if (CE)
		begin
			bus_rst_sync_r <= bus_rst_sync_nxt;
			eep_sync_r <= eep_sync_nxt;
		end
	end

	assign bus_rst = bus_rst_sync_r[1];
	assign ee_present = eep_sync_r[1];

	////////////////////////////////////////////////////////////////////////
	// Identifier load and lock
	load_state_e ld_state_r, ld_state_nxt;
	logic [31:0] uid_upper_r, uid_upper_nxt;
	logic [31:0] uid_lower_r, uid_lower_nxt;
	logic wr_upper, wr_lower;
	logic fw_done_r, fw_done_nxt;
	logic up_done_r, up_done_nxt;

	assign wr_upper = WR && (ADDR == OFS_UID_UPPER);
	assign wr_lower = WR && (ADDR == OFS_UID_LOWER);

	// Window opens when bus reset drops; closes after load completes
	always_comb
	begin
		ld_state_nxt = ld_state_r;
		uid_upper_nxt = uid_upper_r;
		uid_lower_nxt = uid_lower_r;
		fw_done_nxt = fw_done_r;
		up_done_nxt = up_done_r;
		case (ld_state_r)
			LD_WAIT:
			begin
				if (!bus_rst)
					ld_state_nxt = LD_OPEN;
			end
			LD_OPEN:
			begin
				if (ee_present)
				begin
					if (EE_LOAD_VALID)
					begin
						uid_upper_nxt = EE_UID_UPPER;
						uid_lower_nxt = EE_UID_LOWER;
						ld_state_nxt = LD_LOCK;
					end
				end
				else
				begin
					if (wr_upper)
					begin
						uid_upper_nxt = WDATA;
						up_done_nxt = 1'b1;
					end
					if (wr_lower)
					begin
						uid_lower_nxt = WDATA;
						fw_done_nxt = 1'b1;
					end
					// Lock once both quadlets written, in either order
					if ((wr_upper && fw_done_r) || (wr_lower && up_done_r))
						ld_state_nxt = LD_LOCK;
				end
			end
			LD_LOCK:
			begin
				ld_state_nxt = LD_LOCK;
			end
			default:
				ld_state_nxt = LD_WAIT;
		endcase
	end

	// only the global reset clears identifiers
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			ld_state_r <= LD_WAIT;
			uid_upper_r <= UID_RESET;
			uid_lower_r <= UID_RESET;
			fw_done_r <= 1'b0;
			up_done_r <= 1'b0;
		end
		else if (CE)
		begin
			ld_state_r <= ld_state_nxt;
			uid_upper_r <= uid_upper_nxt;
			uid_lower_r <= uid_lower_nxt;
			fw_done_r <= fw_done_nxt;
			up_done_r <= up_done_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// ROM base register and read port
	logic [31:0] rom_base_r, rom_base_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic locked_r, locked_nxt;

	// Register read decode, reused by the read mux
	function automatic logic [31:0] read_word(input logic [7:0] a,
		input logic [31:0] up, input logic [31:0] lo,
		input logic [31:0] base, input logic [1:0] st);
		logic [31:0] v;
		v = 32'h00000000;
		if (a == OFS_UID_UPPER)
			v = up;
		else if (a == OFS_UID_LOWER)
			v = lo;
		else if (a == OFS_ROM_BASE)
			v = base;
		else if (a == OFS_LOAD_CTRL)
			v = {30'h00000000, st};
		else
			v = 32'h00000000;
		return v;
	endfunction

	always_comb
	begin
		rom_base_nxt = rom_base_r;
		if (WR && (ADDR == OFS_ROM_BASE))
			rom_base_nxt = WDATA & ROM_BASE_MASK;
		rdata_nxt = 32'h00000000;
		if (RD)
			rdata_nxt = read_word(ADDR, uid_upper_r, uid_lower_r,
				rom_base_r, ld_state_r);
		locked_nxt = (ld_state_nxt == LD_LOCK);
	end

	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			rom_base_r <= ROM_BASE_RESET;
			rdata_r <= 32'h00000000;
			locked_r <= 1'b0;
		end
		else if (CE)
		begin
			rom_base_r <= rom_base_nxt;
			rdata_r <= rdata_nxt;
			locked_r <= locked_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// ROM window address mapping
	logic hit_r, hit_nxt;
	logic [31:0] haddr_r, haddr_nxt;
	logic in_win;

	assign in_win = (ROM_OFS >= ROM_WIN_LO) && (ROM_OFS <= ROM_WIN_HI);

	// base plus low ten offset bits
	always_comb
	begin
		hit_nxt = ROM_REQ && in_win;
		haddr_nxt = haddr_r;
		if (ROM_REQ && in_win)
			haddr_nxt = rom_base_r +
				{22'h000000, ROM_OFS[ROM_OFS_BITS-1:0]};
	end

	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			hit_r <= 1'b0;
			haddr_r <= 32'h00000000;
		end
		else if (CE)
		begin
			hit_r <= hit_nxt;
			haddr_r <= haddr_nxt;
		end
	end

	assign RDATA = rdata_r;
	assign ROM_HIT = hit_r;
	assign ROM_HOST_ADDR = haddr_r;
	assign UID_LOCKED = locked_r;

	////////////////////////////////////////////////////////////////////////
	// Checks
	AST_UPPER_RESET: assert property (
		@(posedge CLK) SYS_RST |=> (uid_upper_r == 32'h00000000))
		else $error("upper identifier not cleared");
	AST_LOWER_RESET: assert property (
		@(posedge CLK) SYS_RST |=> (uid_lower_r == 32'h00000000))
		else $error("lower identifier not cleared");
	AST_LOCK_HOLD: assert property (
		@(posedge CLK) disable iff (SYS_RST)
		locked_r |=> $stable(uid_upper_r) && $stable(uid_lower_r))
		else $error("identifier changed after lock");
	// Writes before the window opens must not land either
	AST_WAIT_IGNORE: assert property (
		@(posedge CLK) disable iff (SYS_RST)
		(CE && ld_state_r == LD_WAIT) |=>
		$stable(uid_upper_r) && $stable(uid_lower_r))
		else $error("identifier changed before window");
	AST_EE_LOAD: assert property (
		@(posedge CLK) disable iff (SYS_RST)
		(CE && ld_state_r == LD_OPEN && ee_present && EE_LOAD_VALID)
		|=> (uid_upper_r == $past(EE_UID_UPPER)) && locked_r)
		else $error("EEPROM load missed");
	AST_EE_LOWER: assert property (
		@(posedge CLK) disable iff (SYS_RST)
		(CE && ld_state_r == LD_OPEN && ee_present && EE_LOAD_VALID)
		|=> (uid_lower_r == $past(EE_UID_LOWER)))
		else $error("EEPROM lower load missed");
	AST_FW_IGNORE_EE: assert property (
		@(posedge CLK) disable iff (SYS_RST)
		(CE && ld_state_r == LD_OPEN && ee_present && wr_upper
		&& !EE_LOAD_VALID) |=> $stable(uid_upper_r))
		else $error("firmware write taken with EEPROM");
	AST_BUSRST_KEEP: assert property (
		@(posedge CLK) disable iff (SYS_RST)
		(locked_r && bus_rst) |=> locked_r)
		else $error("bus reset disturbed identifiers");
	AST_BASE_LOW0: assert property (
		@(posedge CLK) disable iff (SYS_RST)
		rom_base_r[9:0] == 10'h000)
		else $error("ROM base low bits set");
	AST_BASE_WR: assert property (
		@(posedge CLK) disable iff (SYS_RST)
		(CE && WR && ADDR == OFS_ROM_BASE) |=>
		rom_base_r == ($past(WDATA) & ROM_BASE_MASK))
		else $error("ROM base write lost");
	AST_MAP: assert property (
		@(posedge CLK) disable iff (SYS_RST)
		(CE && ROM_REQ && in_win) |=> ROM_HIT &&
		ROM_HOST_ADDR == $past(rom_base_r) +
		{22'h000000, $past(ROM_OFS[9:0])})
		else $error("ROM address wrong");
	AST_NO_HIT: assert property (
		@(posedge CLK) disable iff (SYS_RST)
		(CE && !(ROM_REQ && in_win)) |=> !ROM_HIT)
		else $error("ROM hit outside window");
	AST_READ_UP: assert property (
		@(posedge CLK) disable iff (SYS_RST)
		(CE && RD && ADDR == OFS_UID_UPPER) |=>
		RDATA == $past(uid_upper_r))
		else $error("upper read wrong");
	AST_READ_LO: assert property (
		@(posedge CLK) disable iff (SYS_RST)
		(CE && RD && ADDR == OFS_UID_LOWER) |=>
		RDATA == $past(uid_lower_r))
		else $error("lower read wrong");

	COV_EE_LOCK: cover property (@(posedge CLK)
		ld_state_r == LD_OPEN && ee_present ##1 locked_r);
	COV_FW_LOCK: cover property (@(posedge CLK)
		ld_state_r == LD_OPEN && !ee_present ##1 locked_r);
	COV_MAP: cover property (@(posedge CLK) ROM_HIT);
endmodule

//--- hdl/uid_rom_pkg.sv
// Package: offsets, fields and reset values of the identifier and ROM map bank
package uid_rom_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_UID_UPPER = 8'h24;
	localparam logic [7:0] OFS_UID_LOWER = 8'h28;
	localparam logic [7:0] OFS_ROM_BASE = 8'h34;
	localparam logic [7:0] OFS_LOAD_CTRL = 8'h30;
	localparam logic [31:0] UID_RESET = 32'h00000000;
	localparam logic [31:0] ROM_BASE_RESET = 32'h00000000;
	localparam logic [31:0] ROM_BASE_MASK = 32'hFFFFFC00;
	localparam int ROM_OFS_BITS = 10;
	localparam logic [47:0] ROM_WIN_LO = 48'hFFFFF0000400;
	localparam logic [47:0] ROM_WIN_HI = 48'hFFFFF00007FF;
	typedef enum logic [1:0] {
		LD_WAIT = 2'b00,
		LD_OPEN = 2'b01,
		LD_LOCK = 2'b11
	} load_state_e;
endpackage

//--- tb/ee_loader_model.sv
// Serial EEPROM loader model that hands over one identifier image
`timescale 1ns/10ps
module ee_loader_model
#(
	parameter int LAT = 5
)
(
	input wire logic clk, // System clock
	input wire logic start, // Held high to request the load
	input wire logic [63:0] image, // Stored identifier image
	output logic valid, // One-cycle word pair valid
	output logic [31:0] upper, // Upper identifier word
	output logic [31:0] lower // Lower identifier word
);
	int cnt = 0;
	logic [63:0] last = 64'h0;
	logic valid_r = 1'b0;
	logic [63:0] word_r = 64'hFFFFFFFFFFFFFFFF;
	// One driver per output, all changes made at the clock edge
	assign valid = valid_r;
	assign upper = word_r[63:32];
	assign lower = word_r[31:0];
	// single load pulse
	// Idle words show the inverse, so stale data cannot pass for a load
	always @(posedge clk)
	begin
		valid_r <= 1'b0;
		word_r <= ~last;
		cnt <= start ? cnt + 1 : 0;
		if (start && cnt == LAT)
		begin
			valid_r <= 1'b1;
			word_r <= image;
			last <= image;
		end
	end
endmodule

//--- tb/tb_top.sv
// Testbench for the identifier registers and the ROM address map
`timescale 1ns/10ps
module tb_top;
	import uid_rom_pkg::*;
	logic clk = 0, rst = 1, bus_rst = 1, ee_pres = 0, ee_go = 0, ce = 1;
	logic wr = 0, rd = 0, req = 0, hit, lock, ee_v;
	logic [7:0] addr = 8'h00;
	logic [31:0] wd = 32'h0, rdata, haddr, ee_u, ee_l;
	logic [47:0] ofs = 48'h0;
	int mismatches = 0, n_tests = 0;
	uid_rom_regs dut (.CLK(clk), .SYS_RST(rst), .CE(ce),
		.HOST_BUS_RESET(bus_rst), .EEPROM_PRESENT(ee_pres),
		.EE_LOAD_VALID(ee_v), .EE_UID_UPPER(ee_u), .EE_UID_LOWER(ee_l),
		.ADDR(addr), .WDATA(wd), .WR(wr), .RD(rd), .RDATA(rdata),
		.ROM_REQ(req), .ROM_OFS(ofs), .ROM_HIT(hit),
		.ROM_HOST_ADDR(haddr), .UID_LOCKED(lock));
	ee_loader_model ee (.clk(clk), .start(ee_go),
		.image(64'h0123456789ABCDEF), .valid(ee_v), .upper(ee_u),
		.lower(ee_l));
	initial
	begin
		forever #5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////
	task final_report;
		if (mismatches == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task rd_chk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	task rom(input logic [47:0] o, input logic h, input logic [31:0] e);
		@(posedge clk);
		req <= 1'b1;
		ofs <= o;
		@(posedge clk);
		req <= 1'b0;
		#1 chk({31'h0, hit}, {31'h0, h});
		if (h)
			chk(haddr, e);
	endtask
	// Bus reset drop, then two sync flops and the open edge
	task bus_pulse;
		@(posedge clk);
		bus_rst <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////////////
	task t_reset;
		wr_reg(OFS_UID_UPPER, 32'h5A5A5A5A);
		rd_chk(OFS_UID_UPPER, 32'h0);
		rd_chk(OFS_UID_LOWER, 32'h0);
		rd_chk(OFS_ROM_BASE, 32'h0);
		rd_chk(OFS_LOAD_CTRL, 32'h0);
		chk({31'h0, lock}, 32'h0);
	endtask
	task t_rom;
		wr_reg(OFS_ROM_BASE, 32'hFFFFFFFF);
		rd_chk(OFS_ROM_BASE, 32'hFFFFFC00);
		wr_reg(OFS_ROM_BASE, 32'h12345678);
		rd_chk(OFS_ROM_BASE, 32'h12345400);
		rom(48'hFFFFF0000400, 1'b1, 32'h12345400);
		rom(48'hFFFFF00007FF, 1'b1, 32'h123457FF);
		rom(48'hFFFFF0000800, 1'b0, 32'h0);
		rom(48'hFFFFF00003FF, 1'b0, 32'h0);
		// Clock enable low must freeze the base register
		@(posedge clk);
		ce <= 1'b0;
		wr_reg(OFS_ROM_BASE, 32'h0000FC00);
		ce <= 1'b1;
		rd_chk(OFS_ROM_BASE, 32'h12345400);
	endtask
	task t_fw;
		bus_pulse;
		rd_chk(OFS_LOAD_CTRL, 32'h1);
		wr_reg(OFS_UID_UPPER, 32'hA5A50001);
		wr_reg(OFS_UID_UPPER, 32'hDEAD0002);
		wr_reg(OFS_UID_LOWER, 32'hBEEF0003);
		@(posedge clk);
		#1 chk({31'h0, lock}, 32'h1);
		rd_chk(OFS_LOAD_CTRL, 32'h3);
		wr_reg(OFS_UID_UPPER, 32'h0);
		rd_chk(OFS_UID_UPPER, 32'hDEAD0002);
		@(posedge clk);
		bus_rst <= 1'b1;
		bus_pulse;
		wr_reg(OFS_UID_LOWER, 32'h0);
		rd_chk(OFS_UID_LOWER, 32'hBEEF0003);
		rd_chk(OFS_UID_UPPER, 32'hDEAD0002);
	endtask
	task t_ee;
		@(posedge clk);
		rst <= 1'b1;
		bus_rst <= 1'b1;
		ee_pres <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd_chk(OFS_UID_UPPER, 32'h0);
		bus_pulse;
		wr_reg(OFS_UID_UPPER, 32'h11111111);
		rd_chk(OFS_UID_UPPER, 32'h0);
		@(posedge clk);
		ee_go <= 1'b1;
		repeat (10) @(posedge clk);
		#1 chk({31'h0, lock}, 32'h1);
		rd_chk(OFS_UID_UPPER, 32'h01234567);
		rd_chk(OFS_UID_LOWER, 32'h89ABCDEF);
		@(posedge clk);
		ee_go <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_rom;
		t_fw;
		t_ee;
		final_report;
	end
	// Watchdog, far beyond the roughly 105 cycles the tests need
	initial
	begin
		#100000;
		mismatches++;
		final_report;
	end
endmodule
